// ### rtl/ddio_top.sv
// Drive digital I/O: enable gating, general purpose input, step/direction demand, status output.
//
// The implementer's own choices: the plain strobed port and the placing of the registers.

// Contract
// [R1] The enabled state follows the drive enable input in normal operation.
// [R2] Enabling is refused unless the enable input is active and no error is latched.
// [R3] Writing the software enable command with one enables, with zero disables.
// [R4] A controller reset clears latched errors and then enables if preconditions hold.
// [R5] Software can read the enable input level but cannot write or force it.
// [R6] The general purpose input is sampled every 500 us and is readable by software.
// [R7] The general purpose input can act as an error, reset or stop input.
// [R8] In position control mode the step and direction inputs give the position demand.
// [R9] Step pulses up to 1 MHz are accepted and the demand rate tracks the step rate.
// [R10] A high direction level steps forward, a low level steps in reverse.
// [R11] Step counts are scaled by a numerator/denominator follow ratio; the code caps ratios above one at one count per step.
// [R12] The status output is recomputed and driven once every 500 us.
// [R13] The status output active polarity is selectable.
// [R14] The status output shows either the enabled state or the global error.
// [R15] Step and direction are synchronised; one count per rising step edge with sampled dir.
// [R16] An active error-function input latches an error that removes the enabled state.
module ddio_top
    import ddio_pkg::*;
#(
    parameter int unsigned SAMPLE_CYC = SAMPLE_CYCLES,
    parameter int unsigned POS_W      = 32
)
(
    // Clock and reset.
    input  wire logic              CLK_SYS,
    input  wire logic              NRST,
    // Register port.
    input  wire logic [7:0]        ADDR,
    input  wire logic [31:0]       WDATA,
    input  wire logic              WR,
    input  wire logic              RD,
    output logic      [31:0]       RDATA,
    // Drive pins.
    input  wire logic              DRIVE_ENABLE_IN,
    input  wire logic              GENERAL_PURPOSE_INPUT,
    input  wire logic              STEP_IN,
    input  wire logic              DIR_IN,
    output logic                   STATUS_OUT,
    // Drive core side.
    output logic                   DRIVE_ENABLED,
    output logic                   DRIVE_STOP,
    output logic                   POS_DEMAND_VALID,
    output logic signed [POS_W-1:0] POS_DEMAND
);

    // ****************************************************************
    // Register bus decode
    // ****************************************************************
    ddio_bus_req_type req;
    assign req = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

    logic wr_ctl;
    logic wr_cfg;
    logic wr_num;
    logic wr_den;
    assign wr_ctl = req.wr && (req.addr == ADDR_CONTROL);
    assign wr_cfg = req.wr && (req.addr == ADDR_CONFIG);
    assign wr_num = req.wr && (req.addr == ADDR_NUMERATOR);
    assign wr_den = req.wr && (req.addr == ADDR_DENOM);

    // ****************************************************************
    // Configuration registers
    // ****************************************************************
    ddio_cfg_type cfg_q;
    logic [31:0]  num_q;
    logic [31:0]  den_q;

    // Config holds gp function, polarity, shown condition and control mode.
    always_ff @(posedge CLK_SYS or negedge NRST)
    begin
        if (!NRST)
        begin
            cfg_q <= '0;
            num_q <= NUMERATOR_RST;
            den_q <= DENOM_RST;
        end
        else
        begin
            if (wr_cfg)
            begin
                cfg_q.gp_func <= ddio_gpfunc_type'(req.wdata[CFG_GPFUNC_LSB +: 2]); // see [R7]
                cfg_q.status_output_polarity <= req.wdata[CFG_POLARITY_BIT];    // see [R13]
                cfg_q.status_shows_global_error <= req.wdata[CFG_SHOWSEL_BIT];  // see [R14]
                cfg_q.pos_mode <= req.wdata[CFG_MODE_BIT];                      // see [R8]
            end
            if (wr_num)
            begin
                num_q <= req.wdata; // see [R11]
            end
            // A zero denominator would make every step a demand count, so it is held at one.
            if (wr_den)
            begin
                den_q <= (req.wdata == '0) ? DENOM_RST : req.wdata; // see [R11]
            end
        end
    end

    // ****************************************************************
    // 500 us sample tick
    // ****************************************************************
    logic [$clog2(SAMPLE_CYC)-1:0] tick_cnt_q;
    logic                          tick;
    assign tick = (tick_cnt_q == ($clog2(SAMPLE_CYC))'(SAMPLE_CYC - 1));

    // Free running divider; one pulse each interval for input and output refresh.
    always_ff @(posedge CLK_SYS or negedge NRST)
    begin
        if (!NRST)
        begin
            tick_cnt_q <= '0;
        end
        else
        begin
            tick_cnt_q <= tick ? '0 : tick_cnt_q + 1'b1;
        end
    end

    // ****************************************************************
    // General purpose input
    // ****************************************************************
    logic gp_q;

    // Sampled only on the tick, so glitches between ticks are never seen.
    always_ff @(posedge CLK_SYS or negedge NRST)
    begin
        if (!NRST)
        begin
            gp_q <= 1'b0;
        end
        else if (tick)
        begin
            gp_q <= GENERAL_PURPOSE_INPUT; // see [R6]
        end
    end

    logic gp_rise;
    logic gp_err_evt;
    logic gp_reset_evt;
    logic gp_stop;
    // Reset acts on an edge so a held input does not re-enable repeatedly.
    assign gp_rise      = tick && GENERAL_PURPOSE_INPUT && !gp_q;
    assign gp_err_evt   = (cfg_q.gp_func == GP_ERROR) && gp_q;          // see [R7]
    assign gp_reset_evt = (cfg_q.gp_func == GP_RESET) && gp_rise;       // see [R7]
    assign gp_stop      = (cfg_q.gp_func == GP_STOP) && gp_q;           // see [R7]

    // ****************************************************************
    // Error latch and enabled state
    // ****************************************************************
    logic sw_reset;
    logic ctl_reset;
    assign sw_reset  = wr_ctl && req.wdata[CTL_RESET_BIT];
    assign ctl_reset = sw_reset || gp_reset_evt;

    logic error_q;
    logic en_q;
    logic en_in_prev_q;
    logic precond;
    // Error clear by a reset happens first, so the reset may enable this very cycle.
    assign precond = DRIVE_ENABLE_IN && (!error_q || ctl_reset) && !gp_err_evt; // see [R2]

    // Error set wins over the clear when both arrive together.
    always_ff @(posedge CLK_SYS or negedge NRST)
    begin
        if (!NRST)
        begin
            error_q <= 1'b0;
        end
        else if (gp_err_evt)
        begin
            error_q <= 1'b1;                                             // see [R16]
        end
        else if (ctl_reset)
        begin
            error_q <= 1'b0;                                             // see [R4]
        end
    end

    // Enable follows the input edges and software; preconditions gate every path.
    always_ff @(posedge CLK_SYS or negedge NRST)
    begin
        if (!NRST)
        begin
            en_q         <= 1'b0;
            en_in_prev_q <= 1'b0;
        end
        else
        begin
            en_in_prev_q <= DRIVE_ENABLE_IN;
            if (!precond)
            begin
                en_q <= 1'b0;                                            // see [R2] [R16]
            end
            else if (ctl_reset)
            begin
                en_q <= 1'b1;                                            // see [R4]
            end
            else if (wr_ctl)
            begin
                en_q <= req.wdata[CTL_ENABLE_BIT];                       // see [R3]
            end
            else if (DRIVE_ENABLE_IN && !en_in_prev_q)
            begin
                en_q <= 1'b1;                                            // see [R1]
            end
        end
    end

    assign DRIVE_ENABLED = en_q;
    assign DRIVE_STOP    = gp_stop;

    // ****************************************************************
    // Step and direction
    // ****************************************************************
    logic step_s1_q;
    logic step_s2_q;
    logic step_s3_q;
    logic dir_s1_q;
    logic dir_s2_q;

    // Two-stage synchronisers; at 20 MHz a 1 MHz step leaves twenty cycles per period.
    always_ff @(posedge CLK_SYS or negedge NRST)
    begin
        if (!NRST)
        begin
            step_s1_q <= 1'b0;
            step_s2_q <= 1'b0;
            step_s3_q <= 1'b0;
            dir_s1_q  <= 1'b0;
            dir_s2_q  <= 1'b0;
        end
        else
        begin
            step_s1_q <= STEP_IN;                                        // see [R15]
            step_s2_q <= step_s1_q;
            step_s3_q <= step_s2_q;
            dir_s1_q  <= DIR_IN;
            dir_s2_q  <= dir_s1_q;
        end
    end

    logic step_evt;
    assign step_evt = step_s2_q && !step_s3_q;                           // see [R15] [R9]

    logic [31:0] step_cnt_q;
    // Raw signed step count, one per rising edge with the direction at that edge.
    always_ff @(posedge CLK_SYS or negedge NRST)
    begin
        if (!NRST)
        begin
            step_cnt_q <= '0;
        end
        else if (step_evt)
        begin
            step_cnt_q <= dir_s2_q ? step_cnt_q + 1'b1 : step_cnt_q - 1'b1; // see [R10]
        end
    end

    // ****************************************************************
    // Follow ratio scaler
    // ****************************************************************
    logic signed [POS_W-1:0] pos_q;
    logic        [32:0]      acc_q;
    logic        [32:0]      acc_sum;
    logic                    carry;
    assign acc_sum = acc_q + {1'b0, num_q};
    assign carry   = (acc_sum >= {1'b0, den_q});

    // Each step adds the numerator; one demand count per denominator reached.
    // Only one count per step is emitted, so ratios above one are limited to unity.
    always_ff @(posedge CLK_SYS or negedge NRST)
    begin
        if (!NRST)
        begin
            acc_q            <= '0;
            pos_q            <= '0;
            POS_DEMAND_VALID <= 1'b0;
        end
        else
        begin
            POS_DEMAND_VALID <= 1'b0;
            if (step_evt && cfg_q.pos_mode)                              // see [R8]
            begin
                POS_DEMAND_VALID <= carry;
                if (carry)
                begin
                    acc_q <= acc_sum - {1'b0, den_q};                    // see [R11]
                    pos_q <= dir_s2_q ? pos_q + 1'b1 : pos_q - 1'b1;     // see [R10]
                end
                else
                begin
                    acc_q <= acc_sum;
                end
            end
        end
    end

    assign POS_DEMAND = pos_q;

    // ****************************************************************
    // Status output
    // ****************************************************************
    logic status_q;
    logic cond;
    assign cond = cfg_q.status_shows_global_error ? error_q : en_q;      // see [R14]

    // Refreshed only on the tick; polarity bit set means asserted drives low.
    always_ff @(posedge CLK_SYS or negedge NRST)
    begin
        if (!NRST)
        begin
            status_q <= 1'b0;
        end
        else if (tick)
        begin
            status_q <= cond ^ cfg_q.status_output_polarity;             // see [R12] [R13]
        end
    end

    assign STATUS_OUT = status_q;

    // ****************************************************************
    // Read data
    // ****************************************************************
    // Enable input is visible in status but has no write path.
    always_ff @(posedge CLK_SYS or negedge NRST)
    begin
        if (!NRST)
        begin
            RDATA <= '0;
        end
        else if (req.rd)
        begin
            case (req.addr)
                ADDR_STATUS:
                begin
                    RDATA <= '0;
                    RDATA[STS_ENABLED_BIT]   <= en_q;
                    RDATA[STS_ERROR_BIT]     <= error_q;
                    RDATA[STS_ENINPUT_BIT]   <= DRIVE_ENABLE_IN;            // see [R5]
                    RDATA[STS_GPINPUT_BIT]   <= gp_q;                       // see [R6]
                    RDATA[STS_STOPPED_BIT]   <= gp_stop;
                    RDATA[STS_STATUSOUT_BIT] <= status_q;
                end
                ADDR_CONTROL:   RDATA <= {31'h0000_0000, en_q};
                ADDR_CONFIG:    RDATA <= {27'h000_0000, cfg_q};
                ADDR_NUMERATOR: RDATA <= num_q;
                ADDR_DENOM:     RDATA <= den_q;
                ADDR_POSITION:  RDATA <= 32'(pos_q);
                ADDR_STEPCNT:   RDATA <= step_cnt_q;
                default:        RDATA <= '0;
            endcase
        end
        else
        begin
            RDATA <= '0;
        end
    end

endmodule

// ### rtl/ddio_pkg.sv
// Package with constants, register map and carrier types of the drive digital I/O block.
package ddio_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int unsigned CLK_HZ          = 20_000_000;
    localparam int unsigned SAMPLE_TIME_US  = 500;
    localparam int unsigned SAMPLE_CYCLES   = (CLK_HZ / 1_000_000) * SAMPLE_TIME_US;
    localparam int unsigned STEP_MAX_HZ     = 1_000_000;
    localparam int unsigned STEP_MIN_CYCLES = CLK_HZ / STEP_MAX_HZ;

    // ****************************************************************
    // Register map (byte addresses of 32-bit words on the plain register port)
    // ****************************************************************
    localparam logic [7:0] ADDR_CONTROL   = 8'h00;
    localparam logic [7:0] ADDR_STATUS    = 8'h04;
    localparam logic [7:0] ADDR_CONFIG    = 8'h08;
    localparam logic [7:0] ADDR_NUMERATOR = 8'h0C;
    localparam logic [7:0] ADDR_DENOM     = 8'h10;
    localparam logic [7:0] ADDR_POSITION  = 8'h14;
    localparam logic [7:0] ADDR_STEPCNT   = 8'h18;

    // Control register bits (write actions).
    localparam int unsigned CTL_ENABLE_BIT = 0;
    localparam int unsigned CTL_RESET_BIT  = 1;

    // Status register bits.
    localparam int unsigned STS_ENABLED_BIT  = 0;
    localparam int unsigned STS_ERROR_BIT    = 1;
    localparam int unsigned STS_ENINPUT_BIT  = 2;
    localparam int unsigned STS_GPINPUT_BIT  = 3;
    localparam int unsigned STS_STOPPED_BIT  = 4;
    localparam int unsigned STS_STATUSOUT_BIT = 5;

    // Config field positions.
    localparam int unsigned CFG_GPFUNC_LSB  = 0;
    localparam int unsigned CFG_POLARITY_BIT = 2;
    localparam int unsigned CFG_SHOWSEL_BIT = 3;
    localparam int unsigned CFG_MODE_BIT    = 4;

    // Reset values.
    localparam logic [31:0] NUMERATOR_RST = 32'h0000_0001;
    localparam logic [31:0] DENOM_RST     = 32'h0000_0001;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [1:0]
    {
        GP_NONE,
        GP_ERROR,
        GP_RESET,
        GP_STOP
    } ddio_gpfunc_type;

    typedef struct packed
    {
        logic            pos_mode;
        logic            status_shows_global_error;
        logic            status_output_polarity;
        ddio_gpfunc_type gp_func;
    } ddio_cfg_type;

    typedef struct packed
    {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } ddio_bus_req_type;

endpackage

// ### sim/ddio_sva.sv
// Concurrent checks on the ports of the drive digital I/O block.
module ddio_sva
#(
    parameter int unsigned POS_W = 32
)
(
    // Clock, reset and register read side.
    input wire logic                    CLK_SYS,
    input wire logic                    NRST,
    input wire logic                    RD,
    input wire logic [31:0]             RDATA,
    // Drive pins.
    input wire logic                    DRIVE_ENABLE_IN,
    input wire logic                    STEP_IN,
    input wire logic                    DIR_IN,
    input wire logic                    STATUS_OUT,
    // Drive core side.
    input wire logic                    DRIVE_ENABLED,
    input wire logic                    DRIVE_STOP,
    input wire logic                    POS_DEMAND_VALID,
    input wire logic signed [POS_W-1:0] POS_DEMAND
);
    // ****************************************************************
    // Port relations
    // ****************************************************************
    // All checks share one clock and are quiet while reset is held.
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!NRST);

    a_input_low_off: assert property (!DRIVE_ENABLE_IN [*4] |-> !DRIVE_ENABLED)
        else $error("enabled while the enable input is low");
    a_enable_needs_input: assert property ($rose(DRIVE_ENABLED) |-> $past(DRIVE_ENABLE_IN))
        else $error("enabled without the enable input");
    a_status_on_tick: assert property ($changed(STATUS_OUT) |=> $stable(STATUS_OUT) [*8])
        else $error("status output changed between ticks");
    a_stop_on_tick: assert property ($changed(DRIVE_STOP) |=> $stable(DRIVE_STOP) [*8])
        else $error("stop request changed between samples");
    // The count lands three edges after a step rise; no step three to five edges back means a count without a step.
    a_step_latency: assert property (POS_DEMAND_VALID |->
        ($past(STEP_IN, 3) || $past(STEP_IN, 4) || $past(STEP_IN, 5)))
        else $error("demand count without a recent step");
    a_valid_pulse: assert property (POS_DEMAND_VALID |=> !POS_DEMAND_VALID)
        else $error("demand valid longer than one cycle");
    a_dir_sign: assert property (POS_DEMAND_VALID |-> ($past(DIR_IN, 4) ?
        POS_DEMAND == $past(POS_DEMAND) + 1 : POS_DEMAND == $past(POS_DEMAND) - 1))
        else $error("demand moved the wrong way");
    a_demand_only_valid: assert property ($changed(POS_DEMAND) |-> POS_DEMAND_VALID)
        else $error("demand moved without a count");
    a_rdata_quiet: assert property (!$past(RD) |-> RDATA == 32'h0000_0000)
        else $error("read data outside the read answer cycle");
endmodule

bind ddio_top ddio_sva #(.POS_W(POS_W)) i_sva (.CLK_SYS(CLK_SYS), .NRST(NRST), .RD(RD),
    .RDATA(RDATA), .DRIVE_ENABLE_IN(DRIVE_ENABLE_IN), .STEP_IN(STEP_IN), .DIR_IN(DIR_IN),
    .STATUS_OUT(STATUS_OUT), .DRIVE_ENABLED(DRIVE_ENABLED), .DRIVE_STOP(DRIVE_STOP),
    .POS_DEMAND_VALID(POS_DEMAND_VALID), .POS_DEMAND(POS_DEMAND));

// ### sim/ddio_step_src.sv
// Motion controller model that sends bursts of step pulses with a direction level.
module ddio_step_src
    import ddio_pkg::*;
(
    // Bench request.
    input  wire logic       clk,
    input  wire logic       go,
    input  wire logic       fwd,
    input  wire logic [7:0] n,
    // Step and direction lines.
    output logic            step,
    output logic            dir,
    output logic            busy
);
    timeunit 1ns;
    timeprecision 1ns;

    // ****************************************************************
    // Pulse generator
    // ****************************************************************
    // Half the 1 MHz period low, half high: the fastest legal source is exercised.
    initial
    begin
        step = 1'b0;
        dir  = 1'b0;
        busy = 1'b0;
        forever
        begin
            @(posedge clk);
            if (go)
            begin
                busy <= 1'b1;
                dir  <= fwd;
                for (int i = 0; i < n; i++)
                begin
                    repeat (STEP_MIN_CYCLES / 2) @(posedge clk);
                    step <= 1'b1;
                    repeat (STEP_MIN_CYCLES / 2) @(posedge clk);
                    step <= 1'b0;
                end
                busy <= 1'b0;
            end
        end
    end
endmodule

// ### sim/tb.sv
// Self-checking bench of the drive digital I/O block.
module tb
    import ddio_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    // ****************************************************************
    // Signals and helpers
    // ****************************************************************
    localparam int          SC   = 16;
    localparam logic [31:0] ONE  = 32'h0000_0001;
    localparam logic [31:0] ZERO = 32'h0000_0000;
    logic               clk_sys, nrst, wr, rd, en_in, gp_in, go, fwd, step, dir;
    logic               st_out, en_out, stop, pv, busy, md, fw;
    logic [7:0]         addr, n;
    logic [31:0]        wdata, rdata, seed;
    logic signed [31:0] pd, pd0;
    int                 n_fail, comparisons, cycles, pulses, num, den, m, p0, sc;

    ddio_top #(.SAMPLE_CYC(SC)) i_dut (.CLK_SYS(clk_sys), .NRST(nrst), .ADDR(addr),
        .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .DRIVE_ENABLE_IN(en_in),
        .GENERAL_PURPOSE_INPUT(gp_in), .STEP_IN(step), .DIR_IN(dir), .STATUS_OUT(st_out),
        .DRIVE_ENABLED(en_out), .DRIVE_STOP(stop), .POS_DEMAND_VALID(pv), .POS_DEMAND(pd));
    ddio_step_src i_src (.clk(clk_sys), .go(go), .fwd(fwd), .n(n), .step(step), .dir(dir),
        .busy(busy));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // Shown condition is enabled (1) or error (0), then inverted by the polarity bit.
    function automatic logic [31:0] st_exp(input logic sel, input logic pol);
        return {31'h0, ~sel ^ pol};
    endfunction

    // Bursts are whole multiples of the denominator, so the remainder always returns to zero.
    function automatic logic [31:0] step_exp(input logic mode, input logic f, input int c);
        int r;
        r = mode ? c : 0;
        return 32'(f ? r : -r);
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge clk_sys);
    endtask

    // An idle edge follows, so back-to-back calls never drive the strobe twice in one step.
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk_sys);
        wr <= 1'b0;
        @(posedge clk_sys);
    endtask

    // Read data is looked at mid-cycle after the strobe, the only cycle it stands.
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] msk, input logic [31:0] exp);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk_sys);
        rd <= 1'b0;
        @(negedge clk_sys);
        chk(rdata & msk, exp);
        @(posedge clk_sys);
    endtask

    task automatic cfg(input logic mo, input logic sel, input logic pol, input ddio_gpfunc_type f);
        wr_reg(ADDR_CONFIG, {27'h0, mo, sel, pol, f});
    endtask

    task automatic conclude();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // ****************************************************************
    // Clock, timeout and demand counting
    // ****************************************************************
    initial
    begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    // A hang is cut short well past the expected run of about nine hundred cycles.
    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        pulses <= pulses + int'(pv);
        if (cycles == 5000)
        begin
            n_fail++;
            conclude();
        end
    end

    // Main sequence.
    initial
    begin
        {nrst, wr, rd, en_in, gp_in, go, fwd, addr, n, wdata} = '0;
        {n_fail, comparisons, cycles, pulses, sc} = '0;
        seed = 32'h0000_a19b;
        tick(2);
        nrst <= 1'b1;
        @(posedge clk_sys);
        rd_chk(ADDR_NUMERATOR, '1, ONE);
        rd_chk(ADDR_DENOM, '1, ONE);
        // A zero denominator is refused and kept at one.
        wr_reg(ADDR_DENOM, ZERO);
        rd_chk(ADDR_DENOM, '1, ONE);
        rd_chk(8'h1C, '1, ZERO);
        en_in <= 1'b1;
        tick(4);
        chk(32'(en_out), ONE);
        wr_reg(ADDR_STATUS, ZERO);
        wr_reg(ADDR_CONTROL, ZERO);
        tick(2);
        chk(32'(en_out), ZERO);
        rd_chk(ADDR_STATUS, 32'h0000_0005, 32'h0000_0004);
        wr_reg(ADDR_CONTROL, ONE);
        tick(2);
        chk(32'(en_out), ONE);
        en_in <= 1'b0;
        tick(4);
        chk(32'(en_out), ZERO);
        wr_reg(ADDR_CONTROL, ONE);
        tick(2);
        chk(32'(en_out), ZERO);
        en_in <= 1'b1;
        tick(4);
        cfg(1'b0, 1'b0, 1'b0, GP_ERROR);
        gp_in <= 1'b1;
        tick(2 * SC + 4);
        rd_chk(ADDR_STATUS, 32'h0000_000B, 32'h0000_000A);
        gp_in <= 1'b0;
        tick(2 * SC + 4);
        wr_reg(ADDR_CONTROL, ONE);
        tick(2);
        chk(32'(en_out), ZERO);
        wr_reg(ADDR_CONTROL, 32'h0000_0002);
        tick(2);
        rd_chk(ADDR_STATUS, 32'h0000_0003, ONE);
        cfg(1'b0, 1'b0, 1'b0, GP_STOP);
        gp_in <= 1'b1;
        tick(2 * SC + 4);
        chk(32'(stop), ONE);
        gp_in <= 1'b0;
        tick(2 * SC + 4);
        chk(32'(stop), ZERO);
        wr_reg(ADDR_CONTROL, ZERO);
        cfg(1'b0, 1'b0, 1'b0, GP_RESET);
        gp_in <= 1'b1;
        tick(2 * SC + 4);
        chk(32'(en_out), ONE);
        gp_in <= 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            cfg(1'b0, i[1], i[0], GP_NONE);
            tick(2 * SC + 2);
            chk(32'(st_out), st_exp(i[1], i[0]));
        end
        // Random ratios and bursts; the first is a fixed one-in-three case, the last is off mode.
        for (int k = 0; k < 6; k++)
        begin
            seed = xs(seed);
            den  = (k == 0) ? 3 : int'(seed[1:0]) + 1;
            num  = (k == 0) ? 1 : int'(seed[3:2]) % den + 1;
            m    = int'(seed[4]) + 1;
            md   = (k != 5);
            fw   = seed[5];
            cfg(md, 1'b0, 1'b0, GP_NONE);
            wr_reg(ADDR_NUMERATOR, 32'(num));
            wr_reg(ADDR_DENOM, 32'(den));
            // The counting process also writes pulses, so a baseline is kept instead.
            pd0    = pd;
            p0     = pulses;
            sc     = sc + (fw ? m * den : -(m * den));
            fwd   <= fw;
            n     <= 8'(m * den);
            go    <= 1'b1;
            tick(1);
            go <= 1'b0;
            tick(1);
            while (busy)
                @(posedge clk_sys);
            tick(8);
            chk(32'(pulses - p0), step_exp(md, 1'b1, num * m));
            chk(pd - pd0, step_exp(md, fw, num * m));
        end
        // The raw count runs in every mode, so the burst with position mode off shows here.
        rd_chk(ADDR_STEPCNT, '1, 32'(sc));
        conclude();
    end
endmodule
